// ===== core/cseq_pkg.sv
package cseq_pkg;

  // Result queue geometry
  localparam int QUEUE_DEPTH = 32;
  localparam int WORD_W = 16;

  // Word addresses on the parallel bus
  localparam logic [3:0] ADDR_STATUS = 4'ha;
  localparam logic [3:0] ADDR_QUEUE = 4'hc;

  // Status word layout
  localparam int ST_LVL_BIT = 2;
  localparam int ST_PAUSE_BIT = 5;
  localparam int ST_IP_LSB = 8;
  localparam int ST_CNT_LSB = 11;
  localparam int ST_CNT_W = 5;

  // Instruction word layout
  localparam int IN_PAUSE_BIT = 0;
  localparam int IN_LOOP_BIT = 1;
  localparam int IN_RES8_BIT = 8;
  localparam int IN_TIMER_BIT = 9;
  localparam int IN_WDOG_BIT = 11;
  localparam int IN_ACQ_LSB = 12;

  // Result word layout and saturation bounds
  localparam int RES_SIGN_BIT = 12;
  localparam logic [3:0] RES8_LOW_FILL = 4'he;
  localparam logic signed [15:0] RES13_MAX = 16'sh0fff;
  localparam logic signed [15:0] RES13_MIN = 16'shf000;
  localparam logic signed [15:0] RES9_MAX = 16'sh00ff;
  localparam logic signed [15:0] RES9_MIN = 16'shff00;

  // State lengths in clock cycles, and the width of the cycle counter
  localparam int CYC_CAL_SHORT = 76;
  localparam int CYC_CAL_FULL = 4944;
  localparam int CYC_TMR_MUL = 32;
  localparam int CYC_TMR_ADD = 2;
  localparam int CYC_ACQ13_BASE = 9;
  localparam int CYC_ACQ9_BASE = 2;
  localparam int CYC_ACQ_MUL = 2;
  localparam int CYC_CMP1 = 5;
  localparam int CYC_CONV13 = 44;
  localparam int CYC_CONV9 = 21;
  localparam int CYC_WDOG = 5;
  localparam int CNT_W = 21;

  // Sequencer states, coded with their state numbers
  typedef enum logic [2:0] {
    CSEQ_S0 = 3'b000,
    CSEQ_S1 = 3'b001,
    CSEQ_S2 = 3'b010,
    CSEQ_S3 = 3'b011,
    CSEQ_S4 = 3'b100,
    CSEQ_S5 = 3'b101,
    CSEQ_S6 = 3'b110,
    CSEQ_S7 = 3'b111
  } cseq_state_t;

endpackage : cseq_pkg

// ===== core/cseq_queue_mem.sv
`timescale 1ns/1ns
module cseq_queue_mem
  import cseq_pkg::*;
#(
  parameter int DEPTH = QUEUE_DEPTH,
  parameter int WIDTH = WORD_W,
  parameter int AW = $clog2(DEPTH)
)
(
  // Clock and control
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // Write port
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  // Registered read port
  input wire logic [AW-1:0] rd_addr_in,
  output logic [WIDTH-1:0] rd_data_out
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Storage has no reset; only the read register starts defined
  always_ff @(posedge clk_in)
  begin
    if (ce_in && wr_en_in)
    begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  // Read data lag the address by one cycle
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      rd_data_out <= '0;
    end
    else if (ce_in)
    begin
      rd_data_out <= mem[rd_addr_in];
    end
  end

endmodule : cseq_queue_mem

// ===== core/cseq_result_fmt.sv
`timescale 1ns/1ns
module cseq_result_fmt
  import cseq_pkg::*;
(
  // Clock and control
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // Raw code and format selects
  input wire logic signed [15:0] code_in,
  input wire logic res8_in,
  input wire logic tag_ip_in,
  input wire logic [2:0] ip_in,
  // Packed queue word
  output logic [WORD_W-1:0] word_out
);

  logic [WORD_W-1:0] word_next;

  // Saturate, place the code, then fill the top three bits
  always_comb
  begin
    logic signed [15:0] sat;
    sat = code_in;
    word_next = '0;
    if (res8_in)
    begin
      if (code_in > RES9_MAX)
        sat = RES9_MAX; // R22
      else if (code_in < RES9_MIN)
        sat = RES9_MIN; // R22
      word_next[RES_SIGN_BIT:0] = {sat[8:0], RES8_LOW_FILL}; // R2
    end
    else
    begin
      if (code_in > RES13_MAX)
        sat = RES13_MAX; // R22
      else if (code_in < RES13_MIN)
        sat = RES13_MIN; // R22
      word_next[RES_SIGN_BIT:0] = sat[12:0]; // R2
    end
    word_next[15:13] = tag_ip_in ? ip_in : {3{word_next[RES_SIGN_BIT]}}; // R3
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      word_out <= '0;
    else if (ce_in)
      word_out <= word_next;
  end

endmodule : cseq_result_fmt

// ===== core/cseq_core.sv
`timescale 1ns/1ns
// Functional notes
// [R1] Read-only result queue, 32 words of 16 bits, at word address 1100.
// [R2] Bits 3:0 low result bits or 1110 in 8-bit mode, 11:4 upper, 12 sign.
// [R3] Bits 15:13 hold sign extension or instruction address, per tag select.
// [R4] A write into a full queue drops the oldest word, keeps the newest.
// [R5] Host reads count first and never reads an empty queue.
// [R6] Narrow bus: low byte first; high-byte read pops the word.
// [R7] Threshold all ones with enable raises interrupt at the 31st result.
// [R8] Clearing start mid-conversion finishes and stores it, then halts.
// [R9] Queue interrupt never stops; only pause, start low or reset stop.
// [R10] Pointer clears on reset or after a looping instruction, else increments.
// [R11] With no loop bits the pointer runs to 111 and wraps.
// [R12] Software sets loop on the last instruction when fewer than eight.
// [R13] Instruction pointer readable in status bits 10:8 at any time.
// [R14] State 0 fetches the instruction in exactly one cycle.
// [R15] State 1 tests calibration and start, idles when stopped, else one cycle.
// [R16] Calibration lasts 76 cycles short, 4944 cycles full.
// [R17] Timer state lasts 32T+2 cycles.
// [R18] Acquisition lasts 9+2D cycles at 13 bits, 2+2D otherwise.
// [R19] First comparison lasts exactly 5 cycles.
// [R20] Second limit read lasts exactly one cycle.
// [R21] Conversion lasts 44, 21 or 5 cycles by mode.
// [R22] Results saturate to -4096..4095 or -256..255.
// [R23] Level flag sets when count reaches threshold; status read or reset clears.
// [R24] Transfer request rises with interrupt at threshold, falls when queue empties.
// [R25] State order 0,1,2,3,7,6,4,5; calibration and timer skipped unless asked.
module cseq_core
  import cseq_pkg::*;
#(
  parameter int CAL_FULL_CYCLES = CYC_CAL_FULL,
  parameter int DEPTH = QUEUE_DEPTH
)
(
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // Configuration controls
  input wire logic start_in,
  input wire logic chip_reset_in,
  input wire logic cal_short_in,
  input wire logic cal_full_in,
  input wire logic tag_ip_sel_in,
  input wire logic [15:0] timer_value_in,
  input wire logic [4:0] queue_thr_in,
  input wire logic queue_int_en_in,
  // Instruction memory
  output logic [2:0] instr_addr_out,
  input wire logic [15:0] instr_data_in,
  // Converter code
  input wire logic signed [15:0] conv_code_in,
  // Parallel bus pins
  input wire logic cs_n_in,
  input wire logic rd_n_in,
  input wire logic [3:0] word_addr_in,
  input wire logic byte_lane_select_in,
  input wire logic bus_width_select_in,
  output logic [15:0] data_out,
  output logic data_oe_out,
  // Host signalling
  output logic int_n_out,
  output logic transfer_request_pin_out
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [CNT_W-1:0] CAL_SHORT_M1 = CNT_W'(CYC_CAL_SHORT - 1);
  localparam logic [CNT_W-1:0] CAL_FULL_M1 = CNT_W'(CAL_FULL_CYCLES - 1);
  localparam logic [7:0] PIN_IDLE = 8'hc0;

  // Cycles spent in a state, less one, when it is entered
  function automatic logic [CNT_W-1:0] len_m1(input cseq_state_t s, input logic [15:0] ins,
                                              input logic [15:0] tmr);
    int n;
    n = 1;
    case (s)
      CSEQ_S3: n = CYC_TMR_MUL * int'(tmr) + CYC_TMR_ADD; // R17
      CSEQ_S7: n = ((ins[IN_RES8_BIT] || ins[IN_WDOG_BIT]) ? CYC_ACQ9_BASE : CYC_ACQ13_BASE)
                   + CYC_ACQ_MUL * int'(ins[IN_ACQ_LSB +: 4]); // R18
      CSEQ_S6: n = CYC_CMP1; // R19
      CSEQ_S5: n = ins[IN_WDOG_BIT] ? CYC_WDOG : (ins[IN_RES8_BIT] ? CYC_CONV9 : CYC_CONV13); // R21
      default: n = 1; // R14 R20
    endcase
    return CNT_W'(n - 1);
  endfunction : len_m1

  logic rst;
  assign rst = srst_in | chip_reset_in;

  // Pin synchronisers: {cs_n, rd_n, width, lane, address}
  logic [7:0] pin_meta_reg;
  logic [7:0] pin_sync_reg;
  always_ff @(posedge clk_in)
  begin
    if (rst)
    begin
      pin_meta_reg <= PIN_IDLE;
      pin_sync_reg <= PIN_IDLE;
    end
    else if (ce_in)
    begin
      pin_meta_reg <= {cs_n_in, rd_n_in, bus_width_select_in, byte_lane_select_in, word_addr_in};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Sequencer state
  cseq_state_t st_reg, st_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [2:0] ip_reg, ip_next;
  logic [15:0] instr_reg, instr_next;
  logic start_d_reg, start_d_next;
  logic halted_reg, halted_next;
  logic resume_reg, resume_next;
  logic cal_d_reg, cal_d_next;
  logic cal_pend_reg, cal_pend_next;
  logic cal_full_reg, cal_full_next;
  logic pause_flag_reg, pause_flag_next;
  logic push_c;
  logic seq_last;

  // Queue, flags and host pins
  logic [AW-1:0] wr_ptr_reg, wr_ptr_next;
  logic [AW-1:0] rd_ptr_reg, rd_ptr_next;
  logic [CW-1:0] count_reg, count_next;
  logic lvl_flag_reg, lvl_flag_next;
  logic dma_next;
  logic int_n_next;
  logic lvl_event;

  // Bus read side
  logic rd_act_d_reg, rd_act_d_next;
  logic [3:0] rd_addr_reg, rd_addr_next;
  logic rd_lane_reg, rd_lane_next;
  logic rd_narrow_reg, rd_narrow_next;
  logic [15:0] data_next;
  logic oe_next;
  logic pop_c;
  logic st_clr_c;
  logic rd_act;
  logic [15:0] status_word;
  logic [WORD_W-1:0] mem_rd_data;
  logic [WORD_W-1:0] fmt_word;

  // Sequencer next state; run control is only checked in state 1
  always_comb
  begin
    logic rise_start;
    logic cal_req;
    rise_start = start_in && !start_d_reg;
    cal_req = cal_short_in || cal_full_in;
    st_next = st_reg;
    cnt_next = cnt_reg;
    ip_next = ip_reg;
    instr_next = instr_reg;
    start_d_next = start_in;
    halted_next = halted_reg && !rise_start;
    resume_next = resume_reg || (rise_start && halted_reg);
    cal_d_next = cal_req;
    cal_pend_next = cal_pend_reg;
    cal_full_next = cal_full_reg;
    pause_flag_next = pause_flag_reg && !st_clr_c;
    push_c = 1'b0;
    seq_last = (cnt_reg == '0);
    if (cal_req && !cal_d_reg)
    begin
      cal_pend_next = 1'b1;
      cal_full_next = cal_full_in;
    end
    if (!seq_last)
    begin
      cnt_next = cnt_reg - CNT_W'(1);
    end
    else
    begin
      unique case (st_reg)
        CSEQ_S0:
        begin
          instr_next = instr_data_in; // R14
          st_next = CSEQ_S1;
          cnt_next = len_m1(CSEQ_S1, instr_data_in, timer_value_in);
        end
        CSEQ_S1:
        begin
          // Reset lands here without a fetch, so the word at the pointer is read again
          instr_next = instr_data_in; // R14
          if (cal_pend_reg)
          begin
            st_next = CSEQ_S2; // R25
            cnt_next = cal_full_reg ? CAL_FULL_M1 : CAL_SHORT_M1; // R16
          end
          else if (start_in && !halted_reg)
          begin
            if (instr_data_in[IN_PAUSE_BIT] && !resume_reg)
            begin
              halted_next = 1'b1; // R9
              pause_flag_next = 1'b1;
            end
            else
            begin
              resume_next = 1'b0;
              st_next = instr_data_in[IN_TIMER_BIT] ? CSEQ_S3 : CSEQ_S7; // R25
              cnt_next = len_m1(st_next, instr_data_in, timer_value_in);
            end
          end
        end
        CSEQ_S2:
        begin
          cal_pend_next = 1'b0;
          st_next = CSEQ_S1; // R15
          cnt_next = '0;
        end
        CSEQ_S3:
        begin
          st_next = CSEQ_S7;
          cnt_next = len_m1(CSEQ_S7, instr_reg, timer_value_in);
        end
        CSEQ_S7:
        begin
          st_next = CSEQ_S6;
          cnt_next = len_m1(CSEQ_S6, instr_reg, timer_value_in);
        end
        CSEQ_S6:
        begin
          st_next = CSEQ_S4;
          cnt_next = len_m1(CSEQ_S4, instr_reg, timer_value_in); // R20
        end
        CSEQ_S4:
        begin
          st_next = CSEQ_S5;
          cnt_next = len_m1(CSEQ_S5, instr_reg, timer_value_in);
        end
        CSEQ_S5:
        begin
          // Conversion always completes, start is looked at again in state 1
          push_c = !instr_reg[IN_WDOG_BIT]; // R8
          ip_next = instr_reg[IN_LOOP_BIT] ? 3'h0 : ip_reg + 3'h1; // R10 R11
          st_next = CSEQ_S0;
          cnt_next = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst)
    begin
      st_reg <= CSEQ_S1; // R15
      cnt_reg <= '0;
      ip_reg <= 3'h0; // R10
      instr_reg <= '0;
      start_d_reg <= 1'b0;
      halted_reg <= 1'b0;
      resume_reg <= 1'b0;
      cal_d_reg <= 1'b0;
      cal_pend_reg <= 1'b0;
      cal_full_reg <= 1'b0;
      pause_flag_reg <= 1'b0;
    end
    else if (ce_in)
    begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      ip_reg <= ip_next;
      instr_reg <= instr_next;
      start_d_reg <= start_d_next;
      halted_reg <= halted_next;
      resume_reg <= resume_next;
      cal_d_reg <= cal_d_next;
      cal_pend_reg <= cal_pend_next;
      cal_full_reg <= cal_full_next;
      pause_flag_reg <= pause_flag_next;
    end
  end

  assign instr_addr_out = ip_reg;

  // Queue pointers, level flag and host pins; overflow moves the read side too
  always_comb
  begin
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next = count_reg;
    if (push_c)
    begin
      wr_ptr_next = wr_ptr_reg + AW'(1);
    end
    if (pop_c || (push_c && count_reg == FULL_CNT))
    begin
      rd_ptr_next = rd_ptr_reg + AW'(1); // R4
    end
    if (push_c && !pop_c && count_reg != FULL_CNT)
      count_next = count_reg + CW'(1);
    else if (pop_c && !push_c)
      count_next = count_reg - CW'(1);
    // Set wins over a status read in the same cycle
    lvl_event = push_c && (count_next == {1'b0, queue_thr_in}); // R7 R23
    lvl_flag_next = lvl_event || (lvl_flag_reg && !st_clr_c); // R23
    if (lvl_event && queue_int_en_in)
      dma_next = 1'b1; // R24
    else if (count_next == '0)
      dma_next = 1'b0; // R24
    else
      dma_next = transfer_request_pin_out;
    int_n_next = !(lvl_flag_next && queue_int_en_in); // R7 R9
  end

  always_ff @(posedge clk_in)
  begin
    if (rst)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      lvl_flag_reg <= 1'b0;
      transfer_request_pin_out <= 1'b0;
      int_n_out <= 1'b1;
    end
    else if (ce_in)
    begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
      lvl_flag_reg <= lvl_flag_next;
      transfer_request_pin_out <= dma_next;
      int_n_out <= int_n_next;
    end
  end

  // Status word is assembled live from the block's state
  always_comb
  begin
    status_word = '0;
    status_word[ST_LVL_BIT] = lvl_flag_reg;
    status_word[ST_PAUSE_BIT] = pause_flag_reg;
    status_word[ST_IP_LSB +: 3] = ip_reg; // R13
    status_word[ST_CNT_LSB +: ST_CNT_W] = count_reg[ST_CNT_W-1:0];
  end

  // Bus reads: data latched at strobe start, side effects at strobe end
  always_comb
  begin
    logic rd_start;
    logic rd_end;
    logic [15:0] word;
    rd_act = !pin_sync_reg[7] && !pin_sync_reg[6];
    rd_start = rd_act && !rd_act_d_reg;
    rd_end = !rd_act && rd_act_d_reg;
    rd_act_d_next = rd_act;
    rd_addr_next = rd_addr_reg;
    rd_lane_next = rd_lane_reg;
    rd_narrow_next = rd_narrow_reg;
    data_next = data_out;
    oe_next = rd_act;
    word = '0;
    if (rd_start)
    begin
      rd_addr_next = pin_sync_reg[3:0];
      rd_lane_next = pin_sync_reg[4];
      rd_narrow_next = pin_sync_reg[5];
      if (pin_sync_reg[3:0] == ADDR_QUEUE)
        word = mem_rd_data; // R1
      else if (pin_sync_reg[3:0] == ADDR_STATUS)
        word = status_word;
      if (pin_sync_reg[5])
        data_next = {8'h00, pin_sync_reg[4] ? word[15:8] : word[7:0]}; // R6
      else
        data_next = word;
    end
    // Only the high byte, or a whole word, removes the entry; empty reads leave it
    pop_c = rd_end && (rd_addr_reg == ADDR_QUEUE) && (!rd_narrow_reg || rd_lane_reg)
            && (count_reg != '0); // R1 R6
    st_clr_c = rd_end && (rd_addr_reg == ADDR_STATUS); // R23
  end

  always_ff @(posedge clk_in)
  begin
    if (rst)
    begin
      rd_act_d_reg <= 1'b0;
      rd_addr_reg <= '0;
      rd_lane_reg <= 1'b0;
      rd_narrow_reg <= 1'b0;
      data_out <= '0;
      data_oe_out <= 1'b0;
    end
    else if (ce_in)
    begin
      rd_act_d_reg <= rd_act_d_next;
      rd_addr_reg <= rd_addr_next;
      rd_lane_reg <= rd_lane_next;
      rd_narrow_reg <= rd_narrow_next;
      data_out <= data_next;
      data_oe_out <= oe_next;
    end
  end

  // Result packing follows the converter code by one cycle
  cseq_result_fmt u_fmt (
    .clk_in(clk_in),
    .srst_in(rst),
    .ce_in(ce_in),
    .code_in(conv_code_in),
    .res8_in(instr_reg[IN_RES8_BIT]),
    .tag_ip_in(tag_ip_sel_in),
    .ip_in(ip_reg),
    .word_out(fmt_word)
  );

  cseq_queue_mem #(.DEPTH(DEPTH), .WIDTH(WORD_W), .AW(AW)) u_mem (
    .clk_in(clk_in),
    .srst_in(rst),
    .ce_in(ce_in),
    .wr_en_in(push_c),
    .wr_addr_in(wr_ptr_reg),
    .wr_data_in(fmt_word),
    .rd_addr_in(rd_ptr_reg),
    .rd_data_out(mem_rd_data)
  );

  // Checks on sequencer timing and queue bookkeeping
  logic st_s2;
  logic st_s3;
  logic st_s5;
  logic st_s6;
  assign st_s2 = (st_reg == CSEQ_S2);
  assign st_s3 = (st_reg == CSEQ_S3);
  assign st_s5 = (st_reg == CSEQ_S5);
  assign st_s6 = (st_reg == CSEQ_S6);

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst || !ce_in);

  sequence s_conv_end;
    st_s5 && seq_last;
  endsequence
  sequence s_cmp1_run;
    st_s6 [*5] ##1 (st_reg == CSEQ_S4);
  endsequence

  property p_fetch_one;
    (st_reg == CSEQ_S0) |=> (st_reg == CSEQ_S1);
  endproperty
  a_fetch_one: assert property (p_fetch_one) else $error("fetch state not one cycle"); // R14
  property p_idle_hold;
    (st_reg == CSEQ_S1 && !cal_pend_reg && !start_in) |=> (st_reg == CSEQ_S1);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("left idle without start"); // R15
  property p_cal_short;
    ($rose(st_s2) && !cal_full_reg) |-> ##75 st_s2 ##1 !st_s2;
  endproperty
  a_cal_short: assert property (p_cal_short) else $error("short calibration not 76 cycles"); // R16
  property p_timer_zero;
    ($rose(st_s3) && timer_value_in == 16'h0000) |-> st_s3 ##1 st_s3 ##1 !st_s3;
  endproperty
  a_timer_zero: assert property (p_timer_zero) else $error("timer state with T=0 not 2 cycles"); // R17
  property p_cmp1;
    $rose(st_s6) |-> s_cmp1_run;
  endproperty
  a_cmp1: assert property (p_cmp1) else $error("first comparison not 5 cycles"); // R19
  property p_lim2;
    (st_reg == CSEQ_S4) |=> st_s5;
  endproperty
  a_lim2: assert property (p_lim2) else $error("second limit read not one cycle"); // R20
  property p_conv13;
    ($rose(st_s5) && !instr_reg[IN_RES8_BIT] && !instr_reg[IN_WDOG_BIT]) |-> ##43 st_s5 ##1 !st_s5;
  endproperty
  a_conv13: assert property (p_conv13) else $error("13-bit conversion not 44 cycles"); // R21
  property p_loop;
    (s_conv_end and instr_reg[IN_LOOP_BIT]) |=> (ip_reg == 3'h0);
  endproperty
  a_loop: assert property (p_loop) else $error("pointer not cleared after loop"); // R10
  property p_inc;
    (s_conv_end and !instr_reg[IN_LOOP_BIT]) |=> (ip_reg == $past(ip_reg) + 3'h1);
  endproperty
  a_inc: assert property (p_inc) else $error("pointer did not advance"); // R11
  property p_overflow;
    (push_c && !pop_c && count_reg == FULL_CNT) |=> (count_reg == FULL_CNT && rd_ptr_reg == wr_ptr_reg);
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow did not drop oldest"); // R4
  property p_halt;
    (s_conv_end ##1 (!start_in && !cal_pend_reg) [*3]) |-> (st_reg == CSEQ_S1);
  endproperty
  a_halt: assert property (p_halt) else $error("sequencer ran on with start low"); // R8
  property p_lvl;
    (push_c && count_next == {1'b0, queue_thr_in}) |=> lvl_flag_reg ##0 (int_n_out == !queue_int_en_in);
  endproperty
  a_lvl: assert property (p_lvl) else $error("level flag or interrupt missed"); // R23
  property p_dma_empty;
    (count_reg == '0) |-> !transfer_request_pin_out;
  endproperty
  a_dma_empty: assert property (p_dma_empty) else $error("transfer request high on empty queue"); // R24

endmodule : cseq_core

// ===== tb/cseq_host_model.sv
`timescale 1ns/1ns
module cseq_host_model
  import cseq_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Bus pins toward the device
  output logic cs_n_out,
  output logic rd_n_out,
  output logic [3:0] word_addr_out,
  output logic byte_lane_select_out,
  output logic bus_width_select_out,
  // Device answer
  input wire logic [15:0] data_in,
  input wire logic data_oe_in
);
  // Idle bus at time zero
  initial
  begin
    cs_n_out = 1'b1;
    rd_n_out = 1'b1;
    word_addr_out = 4'h0;
    byte_lane_select_out = 1'b0;
    bus_width_select_out = 1'b0;
  end

  // One read; strobe held until the answer is taken at a rising edge
  task automatic rd(input logic [3:0] a, input logic w, input logic l, output logic [15:0] d, output logic ok);
    int n;
    ok = 1'b0;
    @(negedge clk_in);
    word_addr_out = a;
    bus_width_select_out = w;
    byte_lane_select_out = l;
    cs_n_out = 1'b0;
    rd_n_out = 1'b0;
    for (n = 0; n < 8 && !ok; n++)
    begin
      @(posedge clk_in);
      ok = (data_oe_in === 1'b1);
    end
    d = data_in;
    @(negedge clk_in);
    cs_n_out = 1'b1;
    rd_n_out = 1'b1;
    // Released address shows a changed pattern, never the old one
    word_addr_out = ~a;
    for (n = 0; n < 8 && data_oe_in !== 1'b0; n++)
      @(posedge clk_in);
    // Synchroniser needs the strobe high a while before the next read
    repeat (3) @(negedge clk_in);
  endtask : rd
endmodule : cseq_host_model

// ===== tb/conversion_sequencer_and_result_queue_tb_top.sv
`timescale 1ns/1ns
`define CHK(nm, e, a) \
  begin \
    tests_run++; \
    if ((e) !== (a)) \
    begin \
      mismatches++; \
      $display("wrong value %s exp %h got %h", nm, e, a); \
    end \
  end
module conversion_sequencer_and_result_queue_tb_top
  import cseq_pkg::*;
;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic start = 1'b0;
  logic chip_rst = 1'b0;
  logic cal_s = 1'b0;
  logic tag = 1'b0;
  logic [15:0] tval = 16'h0000;
  logic [4:0] thr = 5'h01;
  logic signed [15:0] code = 16'sh0000;
  logic [15:0] imem [8];
  logic [2:0] ia;
  logic [15:0] dq;
  logic [3:0] wa;
  logic oe, int_n, transfer_request_pin, cs_n, rd_n, lane, bw;
  int mismatches = 0;
  int tests_run = 0;
  int seed = 78965;
  int ip_run = 0;

  // 10 MHz clock
  always #50 clk_in = ~clk_in;

  // Full calibration tied off; short calibration length is checked inside the core
  cseq_core #(.CAL_FULL_CYCLES(20), .DEPTH(QUEUE_DEPTH)) dut (
    .clk_in(clk_in), .srst_in(srst_in), .ce_in(1'b1), .start_in(start), .chip_reset_in(chip_rst),
    .cal_short_in(cal_s), .cal_full_in(1'b0), .tag_ip_sel_in(tag), .timer_value_in(tval),
    .queue_thr_in(thr), .queue_int_en_in(1'b1), .instr_addr_out(ia), .instr_data_in(imem[ia]),
    .conv_code_in(code), .cs_n_in(cs_n), .rd_n_in(rd_n), .word_addr_in(wa), .byte_lane_select_in(lane),
    .bus_width_select_in(bw), .data_out(dq), .data_oe_out(oe), .int_n_out(int_n),
    .transfer_request_pin_out(transfer_request_pin));

  cseq_host_model host (.clk_in(clk_in), .cs_n_out(cs_n), .rd_n_out(rd_n), .word_addr_out(wa),
    .byte_lane_select_out(lane), .bus_width_select_out(bw), .data_in(dq), .data_oe_in(oe));

  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done

  // A wait that ran out ends the run
  task automatic bad(input string s);
    mismatches++;
    $display("wrong value %s exp answer got timeout", s);
    test_done();
  endtask : bad

  task automatic hrd(input logic [3:0] a, input logic w, input logic l, output logic [15:0] d);
    logic ok;
    host.rd(a, w, l, d, ok);
    if (ok !== 1'b1)
      bad("bus");
  endtask : hrd

  // Expected queue word: saturate, pack, then sign or pointer on top
  function automatic logic [15:0] fmt(input int c, input logic r8, input int ip);
    int s;
    logic [15:0] w;
    if (r8)
      s = (c > 255) ? 255 : (c < -256) ? -256 : c;
    else
      s = (c > 4095) ? 4095 : (c < -4096) ? -4096 : c;
    w[12:0] = r8 ? {s[8:0], 4'he} : s[12:0];
    w[15:13] = tag ? 3'(ip & 1) : {3{w[12]}};
    return w;
  endfunction : fmt

  // Stop, wait out the last conversion, then empty the queue
  task automatic drain(input logic r8, input int lo, input int hi, input logic nb);
    logic [15:0] st, d, e;
    int c, i, ip;
    @(negedge clk_in);
    start = 1'b0;
    // Longest instruction here is well under this
    repeat (300) @(posedge clk_in);
    hrd(ADDR_STATUS, 1'b0, 1'b0, st);
    c = (st[15:11] == 5'h00) ? 32 : int'(st[15:11]);
    `CHK("count", 1'b1, c >= lo && c <= hi)
    if (c < 32)
      `CHK("pointer", 3'((ip_run + c) & 1), st[10:8])
    ip = int'(st[10:8]);
    ip_run = ip;
    i = 0;
    if (nb)
    begin
      e = fmt(code, r8, ip + c);
      hrd(ADDR_QUEUE, 1'b1, 1'b0, d);
      `CHK("low byte", {8'h00, e[7:0]}, d)
      hrd(ADDR_QUEUE, 1'b1, 1'b1, d);
      `CHK("high byte", {8'h00, e[15:8]}, d)
      e = fmt(code, r8, ip + c + 1);
      hrd(ADDR_QUEUE, 1'b1, 1'b1, d);
      `CHK("early high", {8'h00, e[15:8]}, d)
      e = fmt(code, r8, ip + c + 2);
      hrd(ADDR_QUEUE, 1'b1, 1'b0, d);
      `CHK("next low", {8'h00, e[7:0]}, d)
      i = 2;
    end
    for (; i < c; i++)
    begin
      hrd(ADDR_QUEUE, 1'b0, 1'b0, d);
      `CHK("entry", fmt(code, r8, ip + c + i), d)
    end
    `CHK("request low", 1'b0, transfer_request_pin)
  endtask : drain

  // Two-instruction program, run until the threshold request appears
  task automatic batch(input int k, input logic r8, input logic nb);
    logic [15:0] st;
    int n;
    @(negedge clk_in);
    imem[0] = {4'($random(seed)), 2'b00, 1'b1, r8, 8'h00};
    imem[1] = {4'($random(seed)), 2'b00, 1'b0, r8, 8'h02};
    code = 16'($random(seed) % 5000);
    tval = 16'($random(seed) & 3);
    tag = 1'($random(seed));
    thr = 5'(k);
    start = 1'b1;
    for (n = 0; n < 20000 && transfer_request_pin !== 1'b1; n++)
      @(posedge clk_in);
    if (transfer_request_pin !== 1'b1)
      bad("request");
    `CHK("interrupt", 1'b0, int_n)
    if (nb)
    begin
      hrd(ADDR_STATUS, 1'b0, 1'b0, st);
      `CHK("count at flag", 5'd31, st[15:11])
      // Let the sequencer overrun the full queue
      repeat (700) @(posedge clk_in);
    end
    drain(r8, nb ? 32 : k, nb ? 32 : k + 1, nb);
    $display("test batch %0d done", k);
  endtask : batch

  initial
  begin
    logic [15:0] rs;
    // Every slot starts as a looping 8-bit instruction
    foreach (imem[j])
      imem[j] = 16'h0102;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    srst_in = 1'b0;
    `CHK("reset request", 1'b0, transfer_request_pin)
    `CHK("reset interrupt", 1'b1, int_n)
    `CHK("reset pointer", 3'h0, ia)
    // Mode stays 8-bit so the already fetched instruction formats alike
    for (int b = 0; b < 3; b++)
      batch(1 + ($random(seed) & 3), 1'b1, 1'b0);
    // Chip reset while running, then a short calibration before the last batch
    @(negedge clk_in);
    start = 1'b1;
    repeat (150) @(posedge clk_in);
    @(negedge clk_in);
    chip_rst = 1'b1;
    @(negedge clk_in);
    chip_rst = 1'b0;
    start = 1'b0;
    cal_s = 1'b1;
    ip_run = 0;
    `CHK("chip reset pointer", 3'h0, ia)
    `CHK("chip reset request", 1'b0, transfer_request_pin)
    `CHK("chip reset interrupt", 1'b1, int_n)
    hrd(ADDR_STATUS, 1'b0, 1'b0, rs);
    `CHK("chip reset status", 6'h00, {rs[15:11], rs[ST_LVL_BIT]})
    repeat (100) @(posedge clk_in);
    $display("test chip reset done");
    batch(31, 1'b0, 1'b1);
    test_done();
  end
endmodule : conversion_sequencer_and_result_queue_tb_top
